// [src/ppaf_regs.svh]
// Constants for the port-pin alternate function block: widths, reset values, timing.
// Assumes a single 10 MHz reference clock; included by bare name.
`ifndef PPAF_REGS_SVH
`define PPAF_REGS_SVH
`define PPAF_PORT_W 8
`define PPAF_LATCH_RST 8'hff
`define PPAF_P7_RST 1'h1
`define PPAF_CLK_NS 100
`define PPAF_MC_NS 600
`define PPAF_RST_MC 2
`define PPAF_RST_CYC ((`PPAF_RST_MC * `PPAF_MC_NS + `PPAF_CLK_NS - 1) / `PPAF_CLK_NS)
`define PPAF_P3_RXD 0
`define PPAF_P3_TXD 1
`define PPAF_P3_IRQ0 2
`define PPAF_P3_IRQ1 3
`define PPAF_P3_T0 4
`define PPAF_P3_T1 5
`define PPAF_P3_WR 6
`define PPAF_P3_RD 7
`define PPAF_P1_IRQ2 4
`define PPAF_P1_TIMER_TWO_RELOAD_TRIGGER 5
`define PPAF_P1_CLK 6
`endif

// [src/ppaf_pkg.sv]
// Types shared by the port-pin alternate function block.
// Assumes the constants header is compiled alongside.
package ppaf_pkg;
	// Alternate outputs that peripherals offer to port 3 and port 1.
	typedef struct packed {
		logic rd_strobe;
		logic wr_strobe;
		logic txd_or_sclk;
		logic rxd_sync_out;
		logic [3:0] cmp_en;
		logic [3:0] cmp_val;
		logic sys_clk;
	} ppaf_alt_out_s;
	// Pin levels handed to peripherals as alternate inputs.
	typedef struct packed {
		logic ext_irq_zero;
		logic ext_irq_one;
		logic ext_irq_two;
		logic ext_irq_three;
		logic ext_irq_four;
		logic ext_irq_five;
		logic ext_irq_six;
		logic ext_irq_seven;
		logic timer_zero_count_in;
		logic timer_one_count_in;
		logic timer_two_reload_trigger;
		logic [3:0] capture_in;
		logic rxd_in;
	} ppaf_alt_in_s;
	// Reset qualifier states.
	typedef enum logic [1:0] {PPAF_RUN, PPAF_COUNT, PPAF_HELD} ppaf_rst_e;
endpackage

// [src/ppaf_rst_qual.sv]
// Reset pin qualifier: filters short low pulses on the external reset pin.
// Assumes the pin is synchronous to ref_clk.
`timescale 1ns/100ps
`include "ppaf_regs.svh"
module ppaf_rst_qual #(
	parameter int HOLD_CYC = `PPAF_RST_CYC
) (
	// Clock and power-on reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// External reset pin and qualified result.
	input wire logic reset_pin_n,
	output logic core_rst_q
);
	ppaf_pkg::ppaf_rst_e state_q;
	logic [7:0] cnt_q;

	// Count low cycles; a shorter low is ignored so glitches cannot reset the core.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ppaf_pkg::PPAF_HELD;
			cnt_q <= 8'h00;
			core_rst_q <= 1'b1;
		end else begin
			case (state_q)
				ppaf_pkg::PPAF_RUN: begin
					cnt_q <= 8'h01;
					if (!reset_pin_n) begin
						state_q <= ppaf_pkg::PPAF_COUNT;
					end
				end
				ppaf_pkg::PPAF_COUNT: begin
					if (reset_pin_n) begin
						state_q <= ppaf_pkg::PPAF_RUN;
					end else if (cnt_q >= 8'(HOLD_CYC - 1)) begin
						state_q <= ppaf_pkg::PPAF_HELD;
						core_rst_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ppaf_pkg::PPAF_HELD: begin
					if (reset_pin_n) begin
						state_q <= ppaf_pkg::PPAF_RUN;
						core_rst_q <= 1'b0;
					end
				end
				default: state_q <= ppaf_pkg::PPAF_HELD;
			endcase
		end
	end
endmodule

// [src/ppaf_top.sv]
// Port pins 1, 3, 6 and 7, alternate functions on ports 1, 3 and 7, and reset qualification.
// Assumes pins are open-drain style with weak pull-up outside; inputs synchronous to ref_clk.
`timescale 1ns/100ps
`include "ppaf_regs.svh"
module ppaf_top #(
	parameter int W = `PPAF_PORT_W,
	parameter int RST_HOLD = `PPAF_RST_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	// CPU latch writes.
	input wire logic p1_wr,
	input wire logic p3_wr,
	input wire logic p7_wr,
	input wire logic [W-1:0] wr_data,
	// Peripheral alternate outputs.
	input wire ppaf_pkg::ppaf_alt_out_s alt_out,
	input wire logic serial_sync_mode,
	// Pin inputs.
	input wire logic [W-1:0] p1_in,
	input wire logic [W-1:0] p3_in,
	input wire logic [W-1:0] p6_in,
	input wire logic p7_in,
	// Pin outputs, low enable pulls the pin low.
	output logic [W-1:0] p1_out,
	output logic [W-1:0] p1_oe_n,
	output logic [W-1:0] p3_out,
	output logic [W-1:0] p3_oe_n,
	output logic p7_out,
	output logic p7_oe_n,
	// Read-back and alternate inputs.
	output logic [W-1:0] p1_rd_q,
	output logic [W-1:0] p3_rd_q,
	output logic [W-1:0] p6_rd_q,
	output logic p7_rd_q,
	output ppaf_pkg::ppaf_alt_in_s alt_in_q,
	output logic core_rst_q
);
	logic [W-1:0] p1_lat_q;
	logic [W-1:0] p3_lat_q;
	logic p7_lat_q;
	logic [W-1:0] p1_alt;
	logic [W-1:0] p3_alt;
	logic [W-1:0] p1_drv_d;
	logic [W-1:0] p3_drv_d;

	ppaf_rst_qual #(.HOLD_CYC(RST_HOLD)) u_rst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reset_pin_n(reset_pin_n),
		.core_rst_q(core_rst_q)
	);

	// Port latches start at one so every pin is a weak-high input.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_lat_q <= `PPAF_LATCH_RST;
			p3_lat_q <= `PPAF_LATCH_RST;
			p7_lat_q <= `PPAF_P7_RST;
		end else if (core_rst_q) begin
			p1_lat_q <= `PPAF_LATCH_RST;
			p3_lat_q <= `PPAF_LATCH_RST;
			p7_lat_q <= `PPAF_P7_RST;
		end else begin
			if (p1_wr) begin
				p1_lat_q <= wr_data;
			end
			if (p3_wr) begin
				p3_lat_q <= wr_data;
			end
			if (p7_wr) begin
				p7_lat_q <= wr_data[0];
			end
		end
	end

	// Alternate outputs; unused positions idle high so they never override the latch.
	always_comb begin
		p3_alt = {W{1'b1}};
		p3_alt[`PPAF_P3_WR] = alt_out.wr_strobe;
		p3_alt[`PPAF_P3_RD] = alt_out.rd_strobe;
		p3_alt[`PPAF_P3_TXD] = alt_out.txd_or_sclk;
		p3_alt[`PPAF_P3_RXD] = serial_sync_mode ? alt_out.rxd_sync_out : 1'b1;
		p1_alt = {W{1'b1}};
		p1_alt[`PPAF_P1_CLK] = alt_out.sys_clk;
	end

	// Pin drive: latch AND alternate, except enabled compare channels bypass the latch.
	always_comb begin
		p3_drv_d = p3_lat_q & p3_alt;
		p1_drv_d = p1_lat_q & p1_alt;
		for (int i = 0; i < 4; i++) begin
			if (alt_out.cmp_en[i]) begin
				p1_drv_d[i] = alt_out.cmp_val[i];
			end
		end
	end

	// Registered pin drivers; a one releases the pin to the weak pull-up.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_out <= '0;
			p3_out <= '0;
			p7_out <= 1'b0;
			p1_oe_n <= '1;
			p3_oe_n <= '1;
			p7_oe_n <= 1'b1;
		end else begin
			p1_out <= '0;
			p3_out <= '0;
			p7_out <= 1'b0;
			p1_oe_n <= p1_drv_d;
			p3_oe_n <= p3_drv_d;
			p7_oe_n <= p7_lat_q;
		end
	end

	// Read-back samples the pin level, not the latch.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_rd_q <= '1;
			p3_rd_q <= '1;
			p6_rd_q <= '0;
			p7_rd_q <= 1'b1;
		end else begin
			p1_rd_q <= p1_in;
			p3_rd_q <= p3_in;
			p6_rd_q <= p6_in;
			p7_rd_q <= p7_in;
		end
	end

	// Alternate inputs reach peripherals as the pin level; a zero latch forces them low.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_in_q <= '1;
		end else begin
			alt_in_q.ext_irq_seven <= p7_in & p7_lat_q;
			alt_in_q.ext_irq_zero <= p3_in[`PPAF_P3_IRQ0] & p3_lat_q[`PPAF_P3_IRQ0];
			alt_in_q.ext_irq_one <= p3_in[`PPAF_P3_IRQ1] & p3_lat_q[`PPAF_P3_IRQ1];
			alt_in_q.timer_zero_count_in <= p3_in[`PPAF_P3_T0] & p3_lat_q[`PPAF_P3_T0];
			alt_in_q.timer_one_count_in <= p3_in[`PPAF_P3_T1] & p3_lat_q[`PPAF_P3_T1];
			alt_in_q.rxd_in <= p3_in[`PPAF_P3_RXD] & p3_lat_q[`PPAF_P3_RXD];
			alt_in_q.ext_irq_three <= p1_in[0] & p1_lat_q[0];
			alt_in_q.ext_irq_four <= p1_in[1] & p1_lat_q[1];
			alt_in_q.ext_irq_five <= p1_in[2] & p1_lat_q[2];
			alt_in_q.ext_irq_six <= p1_in[3] & p1_lat_q[3];
			alt_in_q.capture_in <= p1_in[3:0] & p1_lat_q[3:0];
			alt_in_q.ext_irq_two <= p1_in[`PPAF_P1_IRQ2] & p1_lat_q[`PPAF_P1_IRQ2];
			alt_in_q.timer_two_reload_trigger <=
				p1_in[`PPAF_P1_TIMER_TWO_RELOAD_TRIGGER] & p1_lat_q[`PPAF_P1_TIMER_TWO_RELOAD_TRIGGER];
		end
	end
endmodule

// [tb/ppaf_asserts.sv]
// Checker for the port-pin block, bound to its top module.
// Assumes RST_HOLD matches the hold count of the bound design.
`timescale 1ns/100ps
module ppaf_asserts #(
	parameter int W = 8,
	parameter int RST_HOLD = 3
) (
	// Clock, resets and control.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic p3_wr,
	input wire logic [W-1:0] wr_data,
	input wire ppaf_pkg::ppaf_alt_out_s alt_out,
	input wire logic [W-1:0] p3_in,
	// Watched outputs.
	input wire logic [W-1:0] p1_out,
	input wire logic [W-1:0] p3_out,
	input wire logic p7_out,
	input wire logic [W-1:0] p1_oe_n,
	input wire logic [W-1:0] p3_oe_n,
	input wire logic [W-1:0] p3_rd_q,
	input wire ppaf_pkg::ppaf_alt_in_s alt_in_q,
	input wire logic core_rst_q
);
	logic [7:0] low_cnt_q;

	// All checks share the one clock and the power-on reset.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Consecutive low samples of the reset pin; it saturates so a long hold cannot wrap.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_q <= 8'h00;
		end else if (reset_pin_n) begin
			low_cnt_q <= 8'h00;
		end else if (low_cnt_q != 8'hff) begin
			low_cnt_q <= low_cnt_q + 8'h01;
		end
	end
	out_low_a: assert property (p1_out == 0 && p3_out == 0 && !p7_out)
		else $error("pin data line not low");
	rd_follow_a: assert property (p3_rd_q == $past(p3_in))
		else $error("port read does not follow pins");
	rst_take_a: assert property (low_cnt_q >= 8'(RST_HOLD) |-> core_rst_q)
		else $error("held reset pin not taken");
	short_pulse_a: assert property ($rose(core_rst_q) |-> low_cnt_q >= 8'(RST_HOLD))
		else $error("reset taken on short pulse");
	rst_release_a: assert property (core_rst_q && reset_pin_n |-> ##[1:2] !core_rst_q)
		else $error("reset not released");
	latch_low_a: assert property (p3_wr && !core_rst_q && !wr_data[5] |-> ##2 !p3_oe_n[5])
		else $error("latch zero not driven");
	cmp_drive_a: assert property (alt_out.cmp_en[0] |=> p1_oe_n[0] == $past(alt_out.cmp_val[0]))
		else $error("compare output not on pin");
	wr_strobe_a: assert property (!alt_out.wr_strobe |=> !p3_oe_n[6])
		else $error("write strobe not on pin");
	clk_out_a: assert property (!alt_out.sys_clk |=> !p1_oe_n[6])
		else $error("clock output not on pin");
	irq_gate_a: assert property (!p3_in[2] |=> !alt_in_q.ext_irq_zero)
		else $error("interrupt zero not seen");
	cover property ($rose(core_rst_q));
	cover property (alt_out.cmp_en[0] && !p1_oe_n[0]);
	cover property (!alt_out.rd_strobe && !p3_oe_n[7]);
endmodule
bind ppaf_top ppaf_asserts #(.W(W), .RST_HOLD(RST_HOLD)) u_chk (.*);

// [tb/ppaf_ext.sv]
// Outside circuit on a port: weak pull-up plus optional outside pull-down.
// Assumes low-active output enables from the port logic.
`timescale 1ns/100ps
module ppaf_ext #(
	parameter int W = 8
) (
	// Port drive and outside pull-downs.
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] ext_low,
	// Resolved pin level.
	output logic [W-1:0] pin
);
	// The pull-up wins only when neither side pulls low.
	assign pin = oe_n & ~ext_low;
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the port-pin block with pull-up pin models.
// Assumes one 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 0, rst_n = 0, reset_pin_n = 1, p1_wr = 0, p3_wr = 0, p7_wr = 0;
	logic lo7 = 0, sync = 0, p7_pin, p7_out, p7_oe_n, p7_rd_q, core_rst_q;
	logic [7:0] wr_data = 8'h00, p6_in = 8'h00, lo1 = 8'h00, lo3 = 8'h00, p1_pin, p3_pin;
	logic [7:0] p1_out, p1_oe_n, p3_out, p3_oe_n, p1_rd_q, p3_rd_q, p6_rd_q;
	ppaf_pkg::ppaf_alt_out_s ao = 13'h1e01; // Strobes and clock idle high, no compare.
	ppaf_pkg::ppaf_alt_in_s alt_in_q;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	ppaf_top #(.RST_HOLD(3)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
		.p1_wr(p1_wr), .p3_wr(p3_wr), .p7_wr(p7_wr), .wr_data(wr_data), .alt_out(ao),
		.serial_sync_mode(sync), .p1_in(p1_pin), .p3_in(p3_pin), .p6_in(p6_in), .p7_in(p7_pin),
		.p1_out(p1_out), .p1_oe_n(p1_oe_n), .p3_out(p3_out), .p3_oe_n(p3_oe_n), .p7_out(p7_out),
		.p7_oe_n(p7_oe_n), .p1_rd_q(p1_rd_q), .p3_rd_q(p3_rd_q), .p6_rd_q(p6_rd_q),
		.p7_rd_q(p7_rd_q), .alt_in_q(alt_in_q), .core_rst_q(core_rst_q));
	ppaf_ext u_p1 (.oe_n(p1_oe_n), .ext_low(lo1), .pin(p1_pin));
	ppaf_ext u_p3 (.oe_n(p3_oe_n), .ext_low(lo3), .pin(p3_pin));
	ppaf_ext #(.W(1)) u_p7 (.oe_n(p7_oe_n), .ext_low(lo7), .pin(p7_pin));
	// The clock runs free; a cycle ceiling cuts a hang short.
	initial forever #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Three falling edges cover the two-edge latch-to-pin latency with margin.
	task automatic settle;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic wr(input int port, input logic [7:0] d);
		@(negedge ref_clk);
		wr_data = d;
		p1_wr = (port == 1);
		p3_wr = (port == 3);
		p7_wr = (port == 7);
		@(negedge ref_clk);
		{p1_wr, p3_wr, p7_wr} = 3'h0;
		settle();
	endtask
	task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic c,
		input logic [15:0] exp);
		lo1 = a;
		lo3 = b;
		lo7 = c;
		settle();
		chk(alt_in_q, exp);
		chk(p3_rd_q, {8'h00, ~b});
		chk(p1_rd_q, {8'h00, ~a});
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1;
		for (int i = 0; i < 20 && core_rst_q !== 1'b0; i++) @(negedge ref_clk);
		chk({p1_oe_n, p3_oe_n}, 16'hffff);
		chk(p7_oe_n, 16'h0001);
		pins(8'h00, 8'h00, 1'h0, 16'hffff);
		pins(8'h3f, 8'h00, 1'h0, 16'hc1c1);
		pins(8'h00, 8'h3d, 1'h1, 16'h3e3e);
		pins(8'h00, 8'h00, 1'h0, 16'hffff);
		p6_in = 8'ha5;
		settle();
		chk(p6_rd_q, 8'ha5);
		// The write strobe is pulled low alone, then the read strobe and TXD with it, then RXD once sync mode is set, on a latch of all ones.
		ao = 13'h1601; // Only the write strobe low.
		settle();
		chk(p3_oe_n, 8'hbf);
		ao = 13'h0001; // Both strobes and both serial outputs low, one assignment per step.
		settle();
		chk(p3_oe_n, 8'h3d);
		sync = 1;
		settle();
		chk(p3_oe_n, 8'h3c);
		ao = 13'h1e01;
		sync = 0;
		wr(3, 8'h5a);
		chk(p3_oe_n, 8'h5a);
		chk(p3_rd_q, 8'h5a);
		ao = 13'h1e64; // Clock output low; compare 0 and 1 enabled with values 0 and 1.
		settle();
		chk(p1_oe_n, 8'hbe);
		wr(1, 8'h00);
		chk(p1_oe_n, 8'h02);
		ao = 13'h1e01;
		wr(7, 8'h00);
		chk({p7_oe_n, p7_rd_q, alt_in_q.ext_irq_seven}, 3'h0);
		wr(7, 8'h01);
		chk({p7_oe_n, p7_rd_q, alt_in_q.ext_irq_seven}, 3'h7);
		// A short reset pulse is ignored; a long one reloads every latch.
		reset_pin_n = 0;
		repeat (2) @(negedge ref_clk);
		reset_pin_n = 1;
		settle();
		chk(core_rst_q, 16'h0000);
		reset_pin_n = 0;
		repeat (6) @(negedge ref_clk);
		chk(core_rst_q, 16'h0001);
		reset_pin_n = 1;
		settle();
		chk({core_rst_q, p3_oe_n}, 16'h00ff);
		// A power-on reset in mid-run is checked one falling edge later, after a rising edge, on core_rst_q, p3_oe_n, alt_in_q and p6_rd_q.
		wr(3, 8'h00);
		rst_n = 0;
		@(negedge ref_clk);
		chk({core_rst_q, p3_oe_n}, 16'h01ff);
		chk(alt_in_q, 16'hffff);
		chk(p6_rd_q, 16'h0000);
		rst_n = 1;
		settle();
		chk({core_rst_q, p3_oe_n}, 16'h00ff);
		tally_and_finish();
	end
endmodule
